// ---- rtl/bcs_pkg.sv ----
/*
 bcs_pkg: constants, types and register layout shared by the buck control
 sequencer files. Assumes a 20 MHz pclk.
*/
package bcs_pkg;
   localparam int unsigned CLK_HZ       = 20_000_000;
   localparam int unsigned SW_FAST_HZ   = 1_000_000;
   localparam int unsigned SW_SLOW_HZ   = 550_000;
   localparam logic [5:0]  SW_FAST_CYC  = 6'(CLK_HZ / SW_FAST_HZ);
   localparam logic [5:0]  SW_SLOW_CYC  = 6'(CLK_HZ / SW_SLOW_HZ);
   localparam int unsigned SS_UNIT_MS   = 1;
   localparam int unsigned RETRY_FAST_US = 12000;
   localparam int unsigned RETRY_SLOW_US = 21800;
   localparam int unsigned CYC_PER_US   = CLK_HZ / 1_000_000;
   localparam logic [19:0] DISCH_PERIODS = 20'h03fff;
   localparam int unsigned POK_DB_US    = 20;
   localparam logic [8:0]  POK_DB_CYC   = 9'(POK_DB_US * CYC_PER_US);
   localparam logic [4:0]  DROP_CLOCKS  = 5'h10;
   localparam int unsigned REFRESH_NS   = 200;
   localparam logic [4:0]  REFRESH_CYC  = 5'((REFRESH_NS * CYC_PER_US + 999) / 1000);
   localparam logic [4:0]  DEAD_CYC     = 5'h01;
   localparam logic [3:0]  HICCUP_COUNT = 4'hf;
   localparam logic [6:0]  VOUT_FAST_MIN   = 7'h0f;
   localparam logic [6:0]  VOUT_VL_OUT_MIN = 7'h14;
   localparam int unsigned TMR_W        = 20;

   // register indices; byte address is four times the index
   localparam logic [5:0] REG_CFG_A_IDX  = 6'h00;
   localparam logic [5:0] REG_CFG_B_IDX  = 6'h01;
   localparam logic [5:0] REG_STATUS_IDX = 6'h02;

   localparam int unsigned CFGA_DISCH_BIT = 6;
   localparam int unsigned CFGA_RAMP_LSB  = 4;
   localparam int unsigned CFGA_PEAK_BIT  = 3;
   localparam int unsigned CFGA_MODE_BIT  = 2;
   localparam int unsigned CFGA_LOGIC_BIT = 1;
   localparam int unsigned CFGA_ENBIT_BIT = 0;
   localparam logic [7:0]  CFGA_FIXED_RST = 8'h08;

   typedef enum logic [2:0] {
      ST_OFF    = 3'b000,
      ST_SOFT   = 3'b001,
      ST_RUN    = 3'b010,
      ST_STBY   = 3'b011,
      ST_HICCUP = 3'b100,
      ST_THERM  = 3'b101,
      ST_DISCH  = 3'b110
   } bcs_state_t;

   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_HS   = 3'b001,
      PH_DT   = 3'b010,
      PH_LS   = 3'b011,
      PH_DTH  = 3'b100,
      PH_REF  = 3'b101
   } bcs_phase_t;

   typedef struct packed {
      logic pwm_trip;
      logic peak_hit;
      logic zero_cross;
      logic neg_hit;
      logic valley_low;
      logic below_25;
      logic above_92;
      logic below_90;
      logic below_102;
      logic light_load;
      logic overtemp;
      logic dropout;
   } bcs_comp_t;
endpackage : bcs_pkg

// ---- rtl/bcs_sync.sv ----
/*
 bcs_sync: two-flop synchroniser for a vector of independent levels.
 Assumes each bit is a slow level; no word coherence across bits.
*/
`timescale 1ns/1ps
`default_nettype none
module bcs_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         q      <= '0;
      end
      else
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : bcs_sync
`default_nettype wire

// ---- rtl/bcs_timer.sv ----
/*
 bcs_timer: loadable down-counter with a tick input and a zero flag.
 Assumes a loaded value of at least one.
*/
`timescale 1ns/1ps
`default_nettype none
module bcs_timer (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic                      load,
   input  wire logic [bcs_pkg::TMR_W-1:0] value,
   input  wire logic                      tick,
   output logic                           done
);
   import bcs_pkg::*;
   logic [TMR_W-1:0] cnt_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= '0;
      else if (load)
         cnt_q <= value;
      else if (tick && cnt_q != '0)
         cnt_q <= cnt_q - 1'b1;
   end

   assign done = (cnt_q == '0);
endmodule : bcs_timer
`default_nettype wire

// ---- rtl/bcs_buck_ctrl.sv ----
/*
 bcs_buck_ctrl: sequencing and switching control of a synchronous buck,
 with its configuration registers on an APB slave.
 Assumes comparator, thermal, lockout and enable inputs are asynchronous
 levels; the power stage obeys the switch commands.
*/
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module bcs_buck_ctrl #(
   parameter logic [19:0] SS_MS_CYC      = 20'(bcs_pkg::CLK_HZ / 1000 * bcs_pkg::SS_UNIT_MS),
   parameter logic [19:0] RETRY_FAST_CYC = 20'(bcs_pkg::RETRY_FAST_US * bcs_pkg::CYC_PER_US),
   parameter logic [19:0] RETRY_SLOW_CYC = 20'(bcs_pkg::RETRY_SLOW_US * bcs_pkg::CYC_PER_US),
   parameter bit          EXT_FEEDBACK   = 1'b0,
   parameter logic [1:0]  RAMP_DEFAULT   = 2'h0,
   parameter bit          DISCH_DEFAULT  = 1'b0,
   parameter logic [6:0]  VOUT_DEFAULT   = 7'h14
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              en_pin,
   input  wire logic              bias_enable_pin,
   input  wire logic              supply_uvlo,
   input  wire bcs_pkg::bcs_comp_t comp,
   output logic                   high_side_switch,
   output logic                   low_side_switch,
   output logic                   switch_node_hiz,
   output logic                   discharge_on,
   output logic                   power_good_output,
   output logic                   power_good_oe_n,
   output logic                   internal_logic_supply,
   output logic                   serial_enable,
   output logic                   logic_supply_from_out,
   output logic                   peak_limit_sel,
   output logic                   negative_limit_en,
   output logic                   switch_freq_slow
);
   import bcs_pkg::*;

   localparam logic [7:0] CFGA_RST = CFGA_FIXED_RST
      | ({7'h00, DISCH_DEFAULT} << CFGA_DISCH_BIT)
      | ({6'h00, RAMP_DEFAULT} << CFGA_RAMP_LSB);
   localparam logic [7:0] CFGB_RST = {1'b0, VOUT_DEFAULT};

   function automatic logic [19:0] ramp_len(input logic [1:0] sel);
      ramp_len = SS_MS_CYC << sel;
   endfunction : ramp_len

   function automatic logic active_st(input bcs_state_t s);
      active_st = (s == ST_RUN) || (s == ST_STBY);
   endfunction : active_st

   logic [14:0] syn;
   bcs_comp_t   c;
   logic        en_s;
   logic        bias_s;
   logic        uvlo_s;

   bcs_sync #(.W(15)) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({en_pin, bias_enable_pin, supply_uvlo, comp}),
      .q     (syn)
   );
   assign {en_s, bias_s, uvlo_s, c} = syn;

   logic [7:0]  cfg_a_q;
   logic [7:0]  cfg_b_q;
   bcs_state_t  st_q;
   bcs_state_t  st_d;
   bcs_phase_t  ph_q;
   logic        pok_q;
   logic        act_forced_pwm_mode_q;
   logic        act_peak_q;
   logic        freq_slow_q;
   logic [5:0]  div_q;
   logic        sw_tick;
   logic        tmr_load;
   logic [19:0] tmr_val;
   logic        tmr_done;
   logic [3:0]  ilim_q;

   // APB: one wait state, answer on the second access cycle
   logic        access;
   logic        addr_hit;
   logic        acc_ok;
   logic [31:0] rd_val;

   assign access   = psel && penable && !pready;
   assign addr_hit = (paddr[1:0] == 2'b00) && (paddr[7:2] <= REG_STATUS_IDX);
   // serial port alive with either pin, refused in lockout
   assign acc_ok   = (en_s || bias_s) && !uvlo_s;

   always_comb
   begin
      rd_val = 32'h0000_0000;
      case (paddr[7:2])
         REG_CFG_A_IDX:  rd_val = {24'h00_0000, cfg_a_q};
         REG_CFG_B_IDX:  rd_val = {24'h00_0000, cfg_b_q};
         REG_STATUS_IDX: rd_val = {20'h0_0000, ilim_q, pok_q, ph_q, st_q, 1'b0};
         default:        rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready <= access;
         if (access)
         begin
            pslverr <= !acc_ok || !addr_hit;
            prdata  <= (acc_ok && addr_hit && !pwrite) ? rd_val : 32'h0000_0000;
         end
      end
   end

   // configuration registers
   logic wr_fire;
   assign wr_fire = psel && penable && pready && pwrite && acc_ok && addr_hit;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg_a_q <= CFGA_RST;
         cfg_b_q <= CFGB_RST;
      end
      else if (uvlo_s)
      begin
         cfg_a_q <= CFGA_RST;
         cfg_b_q <= CFGB_RST;
      end
      else if (wr_fire)
      begin
         if (paddr[7:2] == REG_CFG_A_IDX)
            cfg_a_q <= pwdata[7:0];
         if (paddr[7:2] == REG_CFG_B_IDX)
            cfg_b_q <= pwdata[7:0];
      end
   end

   // switching clock divider and per-cycle configuration latch
   logic slow_cfg;
   // frequency from feedback type and target
   assign slow_cfg = !EXT_FEEDBACK && (cfg_b_q[6:0] < VOUT_FAST_MIN);
   assign sw_tick  = (div_q == 6'h00);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div_q <= 6'h00;
      else if (sw_tick)
         div_q <= (freq_slow_q ? SW_SLOW_CYC : SW_FAST_CYC) - 6'h01;
      else
         div_q <= div_q - 6'h01;
   end

   // settings take hold at the next switching tick
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         act_forced_pwm_mode_q  <= 1'b0;
         act_peak_q  <= 1'b1;
         freq_slow_q <= 1'b0;
      end
      else if (sw_tick)
      begin
         act_forced_pwm_mode_q  <= cfg_a_q[CFGA_MODE_BIT];
         act_peak_q  <= cfg_a_q[CFGA_PEAK_BIT];
         freq_slow_q <= slow_cfg;
      end
   end

   // enable combination
   logic eff_en;
   logic off_req;
   logic disch_ok;
   logic hic_trip;
   assign eff_en   = cfg_a_q[CFGA_LOGIC_BIT] ? (en_s && cfg_a_q[CFGA_ENBIT_BIT])
                                             : (en_s || cfg_a_q[CFGA_ENBIT_BIT]);
   assign off_req  = !eff_en || uvlo_s;
   assign disch_ok = !EXT_FEEDBACK && cfg_a_q[CFGA_DISCH_BIT];
   assign hic_trip = c.below_25 && (ilim_q == HICCUP_COUNT);

   bcs_timer u_timer (
      .clk   (pclk),
      .rst_n (presetn),
      .load  (tmr_load),
      .value (tmr_val),
      .tick  ((st_q == ST_DISCH) ? sw_tick : 1'b1),
      .done  (tmr_done)
   );

   always_comb
   begin
      st_d     = st_q;
      tmr_load = 1'b0;
      tmr_val  = ramp_len(cfg_a_q[CFGA_RAMP_LSB +: 2]);
      case (st_q)
         ST_OFF:
            // ramp on enable or lockout exit
            if (eff_en && !uvlo_s && !c.overtemp)
            begin
               st_d     = ST_SOFT;
               tmr_load = 1'b1;
            end
         ST_SOFT, ST_RUN, ST_STBY, ST_HICCUP, ST_THERM:
            if (off_req)
            begin
               st_d     = (disch_ok && !uvlo_s) ? ST_DISCH : ST_OFF;
               tmr_load = disch_ok && !uvlo_s;
               tmr_val  = DISCH_PERIODS;
            end
            else if (st_q == ST_THERM)
            begin
               if (!c.overtemp)
               begin
                  st_d     = ST_SOFT;
                  tmr_load = 1'b1;
               end
            end
            else if (c.overtemp)
               st_d = ST_THERM;
            else if (st_q == ST_HICCUP)
            begin
               if (tmr_done)
               begin
                  st_d     = ST_SOFT;
                  tmr_load = 1'b1;
               end
            end
            else if (hic_trip)
            begin
               st_d     = ST_HICCUP;
               tmr_load = 1'b1;
               tmr_val  = freq_slow_q ? RETRY_SLOW_CYC : RETRY_FAST_CYC;
            end
            else if (st_q == ST_SOFT)
            begin
               if (tmr_done)
                  st_d = ST_RUN;
            end
            else if (st_q == ST_RUN)
            begin
               if (!act_forced_pwm_mode_q && c.light_load && !c.below_102)
                  st_d = ST_STBY;
            end
            else if (c.below_102 || act_forced_pwm_mode_q)
               st_d = ST_RUN;
         ST_DISCH:
            if (uvlo_s)
               st_d = ST_OFF;
            else if (eff_en && !c.overtemp)
            begin
               st_d     = ST_SOFT;
               tmr_load = 1'b1;
            end
            else if (tmr_done)
               st_d = ST_OFF;
         default:
            st_d = ST_OFF;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_q <= ST_OFF;
      else
         st_q <= st_d;
   end

   // switching phase sequencer
   logic       sw_active;
   logic       valley_block;
   logic [4:0] pcnt_q;
   logic [4:0] drop_q;

   assign sw_active    = (st_q == ST_SOFT) || (st_q == ST_RUN);
   assign valley_block = c.below_25 && !c.valley_low;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ph_q   <= PH_IDLE;
         pcnt_q <= 5'h00;
         drop_q <= 5'h00;
         ilim_q <= 4'h0;
      end
      else if (!sw_active)
      begin
         ph_q   <= PH_IDLE;
         pcnt_q <= 5'h00;
         drop_q <= 5'h00;
         ilim_q <= 4'h0;
      end
      else
      begin
         case (ph_q)
            PH_IDLE:
               // on-time starts on the clock tick
               if (sw_tick && !valley_block)
               begin
                  ph_q   <= PH_HS;
                  drop_q <= 5'h00;
               end
            PH_HS:
               if (c.peak_hit)
               begin
                  ph_q   <= PH_DT;
                  pcnt_q <= 5'h00;
                  if (ilim_q != HICCUP_COUNT)
                     ilim_q <= ilim_q + 4'h1;
               end
               else if (c.pwm_trip)
               begin
                  ph_q   <= PH_DT;
                  pcnt_q <= 5'h00;
                  ilim_q <= 4'h0;
               end
               else if (sw_tick)
               begin
                  if (drop_q == DROP_CLOCKS - 5'h01)
                  begin
                     ph_q   <= PH_REF;
                     pcnt_q <= 5'h00;
                  end
                  else
                     drop_q <= drop_q + 5'h01;
               end
            PH_DT, PH_DTH:
               if (pcnt_q == DEAD_CYC - 5'h01)
               begin
                  ph_q   <= (ph_q == PH_DT) ? PH_LS : PH_HS;
                  pcnt_q <= 5'h00;
                  drop_q <= 5'h00;
               end
               else
                  pcnt_q <= pcnt_q + 5'h01;
            PH_LS:
               if (sw_tick)
                  ph_q <= valley_block ? PH_IDLE : PH_DTH;
               else if (!act_forced_pwm_mode_q && c.zero_cross)
                  ph_q <= PH_IDLE;
               else if (act_forced_pwm_mode_q && c.neg_hit)
                  ph_q <= PH_IDLE;
            PH_REF:
               if (pcnt_q == REFRESH_CYC - 5'h01)
               begin
                  ph_q   <= PH_HS;
                  pcnt_q <= 5'h00;
                  drop_q <= 5'h00;
               end
               else
                  pcnt_q <= pcnt_q + 5'h01;
            default:
               ph_q <= PH_IDLE;
         endcase
      end
   end

   // power good with debounce
   logic [8:0] db_q;
   logic       pok_want;
   assign pok_want = pok_q ? c.below_90 : c.above_92;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pok_q <= 1'b0;
         db_q  <= 9'h000;
      end
      else if (!active_st(st_q))
      begin
         pok_q <= 1'b0;
         db_q  <= 9'h000;
      end
      // crossing must persist for the debounce time
      else if (pok_want)
      begin
         if (db_q == POK_DB_CYC - 9'h001)
         begin
            pok_q <= !pok_q;
            db_q  <= 9'h000;
         end
         else
            db_q <= db_q + 9'h001;
      end
      else
         db_q <= 9'h000;
   end

   // registered outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         high_side_switch      <= 1'b0;
         low_side_switch       <= 1'b0;
         switch_node_hiz       <= 1'b1;
         discharge_on          <= 1'b0;
         power_good_output     <= 1'b0;
         power_good_oe_n       <= 1'b0;
         internal_logic_supply <= 1'b0;
         serial_enable         <= 1'b0;
         logic_supply_from_out <= 1'b0;
         peak_limit_sel        <= 1'b1;
         negative_limit_en     <= 1'b0;
         switch_freq_slow      <= 1'b0;
      end
      else
      begin
         high_side_switch  <= sw_active && (ph_q == PH_HS);
         low_side_switch   <= sw_active && ((ph_q == PH_LS) || (ph_q == PH_REF));
         switch_node_hiz   <= !sw_active || (ph_q == PH_IDLE)
                              || (ph_q == PH_DT) || (ph_q == PH_DTH);
         discharge_on      <= (st_q == ST_DISCH);
         power_good_output <= 1'b0;
         // open drain: pulls low unless good
         power_good_oe_n   <= pok_q;
         internal_logic_supply <= en_s || bias_s;
         serial_enable         <= en_s || bias_s;
         // supply source moves to the output
         logic_supply_from_out <= !EXT_FEEDBACK && active_st(st_q) && pok_q
                                  && (cfg_b_q[6:0] >= VOUT_VL_OUT_MIN);
         peak_limit_sel        <= act_peak_q;
         negative_limit_en     <= act_forced_pwm_mode_q;
         switch_freq_slow      <= freq_slow_q;
      end
   end
endmodule : bcs_buck_ctrl
`default_nettype wire

// ---- verification/bcs_monitor.sv ----
/* bcs_monitor: port-level assertions for bcs_buck_ctrl.
   Assumes a bind from the bench and the single pclk domain. */
`timescale 1ns/1ps
`default_nettype none
module bcs_monitor (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic               en_pin,
   input wire logic               bias_enable_pin,
   input wire bcs_pkg::bcs_comp_t comp,
   input wire logic               high_side_switch,
   input wire logic               low_side_switch,
   input wire logic               power_good_output,
   input wire logic               power_good_oe_n,
   input wire logic               internal_logic_supply,
   input wire logic               serial_enable
);
   import bcs_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence apb_take;
      psel && penable && !pready;
   endsequence
   sequence pins_up;
      (en_pin || bias_enable_pin) [*4];
   endsequence
   sequence pins_down;
      (!en_pin && !bias_enable_pin) [*4];
   endsequence
   apb_answer_a: assert property (apb_take |=> pready ##1 !pready)
      else $error("apb answer not one cycle");
   err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("refused access returned data");
   logic_on_a: assert property (pins_up |-> internal_logic_supply && serial_enable)
      else $error("logic supply off with a pin high");
   logic_off_a: assert property (pins_down |-> !internal_logic_supply && !serial_enable)
      else $error("logic supply on with both pins low");
   no_overlap_a: assert property (!(high_side_switch && low_side_switch))
      else $error("both switches on");
   dead_gap_a: assert property ($fell(high_side_switch) |-> !low_side_switch)
      else $error("no dead time after on-time");
   good_rise_a: assert property ($rose(power_good_oe_n) |-> comp.above_92 && !comp.below_90)
      else $error("power good released without output up");
   good_data_a: assert property ($rose(power_good_oe_n) |-> !power_good_output && $past(comp.above_92, 300))
      else $error("power good released early or pin driven high");
endmodule : bcs_monitor
`default_nettype wire

// ---- verification/bcs_stage_model.sv ----
/* bcs_stage_model: power stage and error amp seen from the controller.
   Assumes high_side_switch is a registered level on pclk. */
`timescale 1ns/1ps
`default_nettype none
module bcs_stage_model #(
   parameter int unsigned ON_CYC = 3
) (
   input wire logic pclk,
   input wire logic high_side_switch,
   output logic     pwm_trip
);
   logic [3:0] on_q;
   always_ff @(posedge pclk)
   begin
      on_q <= high_side_switch ? on_q + 4'h1 : 4'h0;
   end
   assign pwm_trip = on_q >= 4'(ON_CYC);
endmodule : bcs_stage_model
`default_nettype wire

// ---- verification/tb.sv ----
/* tb: self-checking bench for bcs_buck_ctrl over APB.
   Assumes shortened ramp and retry counts set at the instance. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import bcs_pkg::*;
   localparam logic [1:0]  RAMP_D   = 2'h1;
   localparam logic [31:0] CFGA_RST = 32'h08 | (32'(RAMP_D) << 4);
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, hs_prev, trip;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic en_pin, bias_enable_pin, supply_uvlo, high_side_switch, low_side_switch;
   logic switch_node_hiz, discharge_on, power_good_output, power_good_oe_n;
   logic internal_logic_supply, serial_enable, logic_supply_from_out;
   logic peak_limit_sel, negative_limit_en, switch_freq_slow;
   bcs_comp_t cmp, comp;
   int fails, total_checks, cnt;
   always_comb
   begin
      comp = cmp;
      comp.pwm_trip = trip;
   end
   bcs_buck_ctrl #(.SS_MS_CYC(20'h14), .RETRY_FAST_CYC(20'h32), .RETRY_SLOW_CYC(20'h5a),
      .RAMP_DEFAULT(RAMP_D)) u_dut (.*);
   bcs_stage_model u_stage (.pclk(pclk), .high_side_switch(high_side_switch), .pwm_trip(trip));
   initial pclk = 1'b0;
   always #25 pclk = ~pclk;
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic count(input int n);
      cnt = 0;
      hs_prev = high_side_switch;
      repeat (n)
      begin
         @(posedge pclk);
         cnt += int'(high_side_switch && !hs_prev);
         hs_prev = high_side_switch;
      end
   endtask : count
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {en_pin, bias_enable_pin, supply_uvlo} = '0;
      cmp = '0;
      fails = 0;
      total_checks = 0;
      presetn = 1'b0;
      wt(12);
      presetn <= 1'b1;
      bias_enable_pin <= 1'b1;
      wt(5);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, CFGA_RST);
      chk(32'(peak_limit_sel), 32'h1);
      apb(1'b0, 8'h0c, 32'h0);
      chk(32'(er), 32'h1);
      $display("reset test done");
      for (int i = 0; i < 4; i++)
      begin
         en_pin <= i[1];
         bias_enable_pin <= i[0];
         wt(6);
         chk(32'(internal_logic_supply), 32'(i != 0));
         if (i == 0)
         begin
            apb(1'b0, 8'h00, 32'h0);
            chk(32'(er), 32'h1);
         end
      end
      $display("pin test done");
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b1, 8'h00, 32'h08 | 32'({i[2], i[0]}));
         en_pin <= i[1];
         wt(30);
         apb(1'b0, 8'h08, 32'h0);
         chk(32'(rd[3:1] != 3'h0), 32'(i[2] ? i[1] & i[0] : i[1] | i[0]));
         chk(32'(discharge_on), 32'h0);
      end
      $display("enable test done");
      cmp.above_92 <= 1'b1;
      wt(500);
      chk(32'(power_good_oe_n), 32'h1);
      cmp.above_92 <= 1'b0;
      cmp.below_90 <= 1'b1;
      wt(450);
      chk(32'(power_good_oe_n), 32'h0);
      cmp.below_90 <= 1'b0;
      $display("power good test done");
      apb(1'b1, 8'h00, 32'h05);
      wt(45);
      chk(32'(negative_limit_en), 32'h1);
      chk(32'(peak_limit_sel), 32'h0);
      count(200);
      chk(32'(cnt >= 9 && cnt <= 11), 32'h1);
      apb(1'b1, 8'h04, 32'h0e);
      wt(80);
      chk(32'(switch_freq_slow), 32'h1);
      count(360);
      chk(32'(cnt >= 9 && cnt <= 11), 32'h1);
      apb(1'b1, 8'h00, 32'h01);
      wt(80);
      chk(32'(negative_limit_en), 32'h0);
      $display("switching test done");
      supply_uvlo <= 1'b1;
      wt(6);
      supply_uvlo <= 1'b0;
      wt(6);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, CFGA_RST);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h14);
      $display("lockout test done");
      cmp.above_92 <= 1'b1;
      wt(500);
      chk(32'(logic_supply_from_out), 32'h1);
      cmp.light_load <= 1'b1;
      wt(6);
      apb(1'b0, 8'h08, 32'h0);
      chk(32'(rd[3:1]), 32'h3);
      chk(32'(switch_node_hiz), 32'h1);
      cmp.light_load <= 1'b0;
      cmp.below_102 <= 1'b1;
      wt(6);
      apb(1'b0, 8'h08, 32'h0);
      chk(32'(rd[3:1]), 32'h2);
      cmp.overtemp <= 1'b1;
      wt(6);
      apb(1'b0, 8'h08, 32'h0);
      chk(32'(rd[3:1]), 32'h5);
      chk(32'(power_good_oe_n), 32'h0);
      cmp.overtemp <= 1'b0;
      wt(6);
      apb(1'b0, 8'h08, 32'h0);
      chk(32'(rd[3:1]), 32'h1);
      apb(1'b1, 8'h00, 32'h48);
      en_pin <= 1'b0;
      wt(6);
      chk(32'(discharge_on), 32'h1);
      en_pin <= 1'b1;
      wt(6);
      chk(32'(discharge_on), 32'h0);
      cmp.below_25 <= 1'b1;
      wt(25);
      count(100);
      chk(32'(cnt), 32'h0);
      cmp.valley_low <= 1'b1;
      cmp.peak_hit <= 1'b1;
      rd = '0;
      for (int k = 0; k < 120 && rd[3:1] != 3'h4; k++)
         apb(1'b0, 8'h08, 32'h0);
      chk(32'(rd[3:1]), 32'h4);
      $display("fault test done");
      wrap_up();
   end
   initial
   begin
      wt(6000);
      fails++;
      wrap_up();
   end
endmodule : tb
bind bcs_buck_ctrl bcs_monitor u_mon (.*);
`default_nettype wire
